// ### hdl/mhp_cfg.svh
/*
  Constants for the mailbox handshake pipe: sizes,
  reset values and fixed encodings, held as macros.
  Assumes it is included by bare name wherever a constant is needed.
*/
`ifndef MHP_CFG_SVH
`define MHP_CFG_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define MHP_NREG        16
`define MHP_NBLK        8
`define MHP_DW          16
`define MHP_AW          4
`define MHP_SELW        4
`define MHP_BLKW        3
`define MHP_FIFO_DEPTH  16
`define MHP_FIFO_W      17

// ----------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------
`define MHP_DIR_SLAVE_TX  1'b1
`define MHP_DIR_MASTER_TX 1'b0
`define MHP_FLAG_SET      1'b1
`define MHP_FLAG_IDLE     1'b0
`define MHP_WORD_RST      16'h0000
`define MHP_IDX_RST       4'h0
`define MHP_DIR_RST       16'h0000
`define MHP_ASG_RST       32'h0000_0000
`define MHP_EN_RST        8'h00

`endif

// ### hdl/mhp_if.sv
/*
  Interface joining the mailbox device to the two processor ports.
  Assumes one clock shared by both parties; the testbench ties it up.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mhp_cfg.svh"

interface mhp_if;
  // Master processor port
  mhp_pkg::mhp_idx_t    m_addr;
  logic                 m_wr;
  logic                 m_rd;
  mhp_pkg::mhp_word_t   m_wdata;
  mhp_pkg::mhp_word_t   m_rdata;
  mhp_pkg::mhp_blkvec_t m_flags;
  mhp_pkg::mhp_blkvec_t m_irq;
  // Slave processor port
  mhp_pkg::mhp_idx_t    s_addr;
  logic                 s_wr;
  logic                 s_rd;
  mhp_pkg::mhp_word_t   s_wdata;
  mhp_pkg::mhp_word_t   s_rdata;
  mhp_pkg::mhp_blkvec_t s_flags;
  mhp_pkg::mhp_blkvec_t s_irq;

  modport dev (
    input  m_addr, m_wr, m_rd, m_wdata,
    input  s_addr, s_wr, s_rd, s_wdata,
    output m_rdata, m_flags, m_irq,
    output s_rdata, s_flags, s_irq
  );

  modport host (
    output m_addr, m_wr, m_rd, m_wdata,
    output s_addr, s_wr, s_rd, s_wdata,
    input  m_rdata, m_flags, m_irq,
    input  s_rdata, s_flags, s_irq
  );
endinterface : mhp_if

`default_nettype wire

// ### hdl/mhp_mailbox_dev.sv
/*
  Mailbox device end: sixteen one-way data words, their direction
  fuses, and eight fuse-assigned handshake blocks with data-ready
  flags and ready-to-read / ready-to-write interrupt pulses.
  Assumes both processor ports run on CLOCK, fuse inputs are stable
  before RESET_N is released, and RESET_N is the master-side reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mhp_cfg.svh"

// Function
// - Data word writable only by its transmitter
// - Direction fuse one means slave transmits
// - Each block keeps transmitter and receiver flags
// - Transmitter alone starts a transfer
// - Receiver data requests are software business
// - Unenabled block stays silent
// - Block n uses fuse bits 4n+3:4n
// - Fuse field is the binary register index
// - Transmitter writes protocol register last
// - Receiver reads protocol register last
// - Idle handshake shows flags cleared
// - Protocol write sets flags, ready-to-read interrupt
// - Protocol read clears flags, ready-to-write interrupt
// - Receiver interrupt rises with its flag
// - Software masks interrupts of unused blocks
// - Other registers never touch the handshake
// - Master reset clears flags, keeps data
// - Read with flag clear only returns data
module mhp_mailbox_dev (
  input  wire logic                  CLOCK,
  input  wire logic                  RESET_N,
  input  wire logic [`MHP_NREG-1:0]  DIR_FUSES,
  input  wire logic [4*`MHP_NBLK-1:0] ASSIGN_FUSES,
  input  wire logic [`MHP_NBLK-1:0]  ENABLE_FUSES,
  mhp_if.dev                         BUS
);

  // ----------------------------------------------------------------
  // Fuse capture
  // ----------------------------------------------------------------
  logic                    fuse_ok_q, fuse_ok_d;
  logic [`MHP_NREG-1:0]    dir_q, dir_d;
  logic [4*`MHP_NBLK-1:0]  asg_q, asg_d;
  logic [`MHP_NBLK-1:0]    en_q, en_d;

  // Fuses are caught once, on the first edge after release; until then
  // every block is disabled and no word can be written
  always_comb begin
    fuse_ok_d = 1'b1;
    dir_d     = fuse_ok_q ? dir_q : DIR_FUSES;
    asg_d     = fuse_ok_q ? asg_q : ASSIGN_FUSES;
    en_d      = fuse_ok_q ? en_q  : ENABLE_FUSES;
  end

  // Reset loads constants only; the straps are sampled afterwards
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      fuse_ok_q <= 1'b0;
      dir_q     <= `MHP_DIR_RST;
      asg_q     <= `MHP_ASG_RST;
      en_q      <= `MHP_EN_RST;
    end else begin
      fuse_ok_q <= fuse_ok_d;
      dir_q     <= dir_d;
      asg_q     <= asg_d;
      en_q      <= en_d;
    end
  end

  // ----------------------------------------------------------------
  // Mailbox data words
  // ----------------------------------------------------------------
  mhp_pkg::mhp_word_t mbx_q [`MHP_NREG];
  mhp_pkg::mhp_word_t mbx_d [`MHP_NREG];
  logic               m_wr_ok, s_wr_ok;

  // Only the transmitting port of a word may change it
  assign m_wr_ok = fuse_ok_q && BUS.m_wr
                   && (dir_q[BUS.m_addr] == `MHP_DIR_MASTER_TX);
  assign s_wr_ok = fuse_ok_q && BUS.s_wr
                   && (dir_q[BUS.s_addr] == `MHP_DIR_SLAVE_TX);

  // At most one port owns a word, so the two writes never collide
  always_comb begin
    mbx_d = mbx_q;
    if (m_wr_ok) begin
      mbx_d[BUS.m_addr] = BUS.m_wdata;
    end
    if (s_wr_ok) begin
      mbx_d[BUS.s_addr] = BUS.s_wdata;
    end
  end

  // No reset on the words: a receiver already reading gets old data
  // rather than a cleared value after a master reset
  always_ff @(posedge CLOCK) begin
    mbx_q <= mbx_d;
  end

  // ----------------------------------------------------------------
  // Read data ports
  // ----------------------------------------------------------------
  mhp_pkg::mhp_word_t m_rdata_q, m_rdata_d;
  mhp_pkg::mhp_word_t s_rdata_q, s_rdata_d;

  // Both ports may read any word; data holds until the next read
  always_comb begin
    m_rdata_d = BUS.m_rd ? mbx_q[BUS.m_addr] : m_rdata_q;
    s_rdata_d = BUS.s_rd ? mbx_q[BUS.s_addr] : s_rdata_q;
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      m_rdata_q <= `MHP_WORD_RST;
      s_rdata_q <= `MHP_WORD_RST;
    end else begin
      m_rdata_q <= m_rdata_d;
      s_rdata_q <= s_rdata_d;
    end
  end

  assign BUS.m_rdata = m_rdata_q;
  assign BUS.s_rdata = s_rdata_q;

  // ----------------------------------------------------------------
  // Handshake blocks
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `MHP_NBLK; g = g + 1) begin : g_blk
      mhp_pkg::mhp_idx_t sel;
      logic              on, tx_slave, tx_wr, rx_rd;
      logic              tx_flag_q, tx_flag_d, rx_flag_q, rx_flag_d;
      logic              wr_ev_q, wr_ev_d, rd_ev_q, rd_ev_d;
      logic              tx_irq_q, tx_irq_d, rx_irq_q, rx_irq_d;

      // Protocol register index and the side that transmits on it
      assign sel      = asg_q[4*g +: `MHP_SELW];
      assign on       = en_q[g];
      assign tx_slave = (dir_q[sel] == `MHP_DIR_SLAVE_TX);

      // Only the transmitter's write to the protocol word starts it;
      // the device offers no request path back from the receiver
      assign tx_wr = on && (tx_slave
                     ? (BUS.s_wr && BUS.s_addr == sel)
                     : (BUS.m_wr && BUS.m_addr == sel));

      // A receiver read counts only while data is pending
      assign rx_rd = on && (rx_flag_q == `MHP_FLAG_SET) && (tx_slave
                     ? (BUS.m_rd && BUS.m_addr == sel)
                     : (BUS.s_rd && BUS.s_addr == sel));

      // Each event acts on its own side at once and on the far side one
      // stage later; a set landing with a clear wins
      always_comb begin
        wr_ev_d   = tx_wr;
        rd_ev_d   = rx_rd;
        tx_flag_d = tx_flag_q;
        rx_flag_d = rx_flag_q;
        if (rd_ev_q) begin
          tx_flag_d = `MHP_FLAG_IDLE;
        end
        if (tx_wr) begin
          tx_flag_d = `MHP_FLAG_SET;
        end
        if (rx_rd) begin
          rx_flag_d = `MHP_FLAG_IDLE;
        end
        if (wr_ev_q) begin
          rx_flag_d = `MHP_FLAG_SET;
        end
        rx_irq_d = wr_ev_q;
        tx_irq_d = rd_ev_q;
      end

      // Master reset idles every block in both views
      always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
          tx_flag_q <= `MHP_FLAG_IDLE;
          rx_flag_q <= `MHP_FLAG_IDLE;
          wr_ev_q   <= 1'b0;
          rd_ev_q   <= 1'b0;
          tx_irq_q  <= 1'b0;
          rx_irq_q  <= 1'b0;
        end else begin
          tx_flag_q <= tx_flag_d;
          rx_flag_q <= rx_flag_d;
          wr_ev_q   <= wr_ev_d;
          rd_ev_q   <= rd_ev_d;
          tx_irq_q  <= tx_irq_d;
          rx_irq_q  <= rx_irq_d;
        end
      end

      // Route the two flags to the master and slave status views
      assign BUS.m_flags[g] = tx_slave ? rx_flag_q : tx_flag_q;
      assign BUS.s_flags[g] = tx_slave ? tx_flag_q : rx_flag_q;
      assign BUS.m_irq[g]   = tx_slave ? rx_irq_q  : tx_irq_q;
      assign BUS.s_irq[g]   = tx_slave ? tx_irq_q  : rx_irq_q;
    end
  endgenerate

endmodule : mhp_mailbox_dev

`default_nettype wire

// ### hdl/mhp_mailbox_host.sv
/*
  Processor-side end: a FIFO-fed master transmit engine and a slave
  receive engine that move word buffers through one handshake block.
  Assumes the chosen block's protocol word and its data words are set
  for master-to-slave transfer, and the device shares CLOCK.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mhp_cfg.svh"

// ------------------------------------------------------------------
// Buffer FIFO
// ------------------------------------------------------------------
module mhp_fifo #(
  parameter int W     = `MHP_FIFO_W,
  parameter int DEPTH = `MHP_FIFO_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [PW:0]   cnt_q, cnt_d;
  logic          push, pop;

  // Full and empty come straight from the occupancy count
  assign in_ready  = (cnt_q != FULL);
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rp_q];

  always_comb begin
    wp_d  = push ? PW'(wp_q + 1'b1) : wp_q;
    rp_d  = pop  ? PW'(rp_q + 1'b1) : rp_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = (PW+1)'(cnt_q + 1'b1);
    end else if (pop && !push) begin
      cnt_d = (PW+1)'(cnt_q - 1'b1);
    end
  end

  // Storage needs no reset; the pointers guard stale entries
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end
endmodule : mhp_fifo

// ------------------------------------------------------------------
// Transmit and receive engines
// ------------------------------------------------------------------
module mhp_mailbox_host (
  input  wire logic                  CLOCK,
  input  wire logic                  RESET_N,
  input  wire logic [`MHP_BLKW-1:0]  BLOCK_SEL,
  input  wire logic [`MHP_AW-1:0]    FIRST_REG,
  input  wire logic [`MHP_AW-1:0]    PROTO_REG,
  input  wire logic [`MHP_AW-1:0]    RX_LEN,
  input  wire logic                  TX_VALID,
  output logic                       TX_READY,
  input  wire logic [`MHP_DW-1:0]    TX_DATA,
  input  wire logic                  TX_LAST,
  output logic                       RX_VALID,
  output logic [`MHP_DW-1:0]         RX_DATA,
  output logic                       RX_LAST,
  mhp_if.host                        BUS
);
  logic [`MHP_FIFO_W-1:0] f_data;
  logic                   f_valid, f_ready, m_flag, s_flag;

  mhp_fifo #(.W(`MHP_FIFO_W), .DEPTH(`MHP_FIFO_DEPTH)) u_fifo (
    .clk       (CLOCK),
    .rst_n     (RESET_N),
    .in_valid  (TX_VALID),
    .in_ready  (TX_READY),
    .in_data   ({TX_LAST, TX_DATA}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  // Only the selected block's flags matter; the others are ignored
  assign m_flag = BUS.m_flags[BLOCK_SEL];
  assign s_flag = BUS.s_flags[BLOCK_SEL];

  // ----------------------------------------------------------------
  // Master transmit engine
  // ----------------------------------------------------------------
  mhp_pkg::mhp_mst_t  mst_q, mst_d;
  mhp_pkg::mhp_idx_t  widx_q, widx_d, m_addr_q, m_addr_d;
  mhp_pkg::mhp_word_t m_wdata_q, m_wdata_d;
  logic               m_wr_q, m_wr_d;

  // Pops stall while the previous buffer is unread, so the FIFO fills
  assign f_ready = (mst_q == mhp_pkg::MHP_M_RUN) && !m_flag;

  always_comb begin
    mst_d     = mst_q;
    widx_d    = widx_q;
    m_wr_d    = 1'b0;
    m_addr_d  = m_addr_q;
    m_wdata_d = m_wdata_q;
    case (mst_q)
      mhp_pkg::MHP_M_RUN: begin
        if (f_valid && f_ready) begin
          m_wr_d    = 1'b1;
          m_wdata_d = f_data[`MHP_DW-1:0];
          if (f_data[`MHP_DW]) begin
            m_addr_d = PROTO_REG;
            widx_d   = `MHP_IDX_RST;
            mst_d    = mhp_pkg::MHP_M_WAIT_SET;
          end else begin
            m_addr_d = `MHP_AW'(FIRST_REG + widx_q);
            widx_d   = `MHP_AW'(widx_q + 1'b1);
          end
        end
      end
      // Wait for the flag to rise, then for the receiver to clear it
      mhp_pkg::MHP_M_WAIT_SET: begin
        if (m_flag) begin
          mst_d = mhp_pkg::MHP_M_WAIT_CLR;
        end
      end
      mhp_pkg::MHP_M_WAIT_CLR: begin
        if (!m_flag) begin
          mst_d = mhp_pkg::MHP_M_RUN;
        end
      end
      default: mst_d = mhp_pkg::MHP_M_RUN;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      mst_q     <= mhp_pkg::MHP_M_RUN;
      widx_q    <= `MHP_IDX_RST;
      m_wr_q    <= 1'b0;
      m_addr_q  <= `MHP_IDX_RST;
      m_wdata_q <= `MHP_WORD_RST;
    end else begin
      mst_q     <= mst_d;
      widx_q    <= widx_d;
      m_wr_q    <= m_wr_d;
      m_addr_q  <= m_addr_d;
      m_wdata_q <= m_wdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Slave receive engine
  // ----------------------------------------------------------------
  mhp_pkg::mhp_slv_t slv_q, slv_d;
  mhp_pkg::mhp_idx_t ridx_q, ridx_d, s_addr_q, s_addr_d;
  logic              s_rd_q, s_rd_d, s_last_q, s_last_d;
  logic              rxv_q, rxv_d, rxl_q, rxl_d;

  // Receiver polls its flag; it never asks the transmitter for data
  always_comb begin
    slv_d    = slv_q;
    ridx_d   = ridx_q;
    s_rd_d   = 1'b0;
    s_last_d = 1'b0;
    s_addr_d = s_addr_q;
    rxv_d    = s_rd_q;
    rxl_d    = s_last_q;
    case (slv_q)
      mhp_pkg::MHP_S_IDLE: begin
        if (s_flag) begin
          ridx_d = `MHP_IDX_RST;
          slv_d  = mhp_pkg::MHP_S_READ;
        end
      end
      mhp_pkg::MHP_S_READ: begin
        s_rd_d = 1'b1;
        if (ridx_q < RX_LEN) begin
          s_addr_d = `MHP_AW'(FIRST_REG + ridx_q);
          ridx_d   = `MHP_AW'(ridx_q + 1'b1);
        end else begin
          s_addr_d = PROTO_REG;
          s_last_d = 1'b1;
          slv_d    = mhp_pkg::MHP_S_DRAIN;
        end
      end
      // Hold off until the protocol read has cleared the flag
      mhp_pkg::MHP_S_DRAIN: begin
        if (!s_flag && !s_rd_q) begin
          slv_d = mhp_pkg::MHP_S_IDLE;
        end
      end
      default: slv_d = mhp_pkg::MHP_S_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      slv_q    <= mhp_pkg::MHP_S_IDLE;
      ridx_q   <= `MHP_IDX_RST;
      s_rd_q   <= 1'b0;
      s_last_q <= 1'b0;
      s_addr_q <= `MHP_IDX_RST;
      rxv_q    <= 1'b0;
      rxl_q    <= 1'b0;
    end else begin
      slv_q    <= slv_d;
      ridx_q   <= ridx_d;
      s_rd_q   <= s_rd_d;
      s_last_q <= s_last_d;
      s_addr_q <= s_addr_d;
      rxv_q    <= rxv_d;
      rxl_q    <= rxl_d;
    end
  end

  // Master never reads and slave never writes in this direction
  assign BUS.m_addr  = m_addr_q;
  assign BUS.m_wr    = m_wr_q;
  assign BUS.m_rd    = 1'b0;
  assign BUS.m_wdata = m_wdata_q;
  assign BUS.s_addr  = s_addr_q;
  assign BUS.s_wr    = 1'b0;
  assign BUS.s_rd    = s_rd_q;
  assign BUS.s_wdata = `MHP_WORD_RST;
  assign RX_VALID    = rxv_q;
  assign RX_LAST     = rxl_q;
  assign RX_DATA     = BUS.s_rdata;
endmodule : mhp_mailbox_host

`default_nettype wire

// ### hdl/mhp_pkg.sv
/*
  Types shared by both ends of the mailbox handshake pipe.
  Assumes mhp_cfg.svh is reachable on the include path.
*/
`include "mhp_cfg.svh"

package mhp_pkg;

  // ----------------------------------------------------------------
  // Data and index types
  // ----------------------------------------------------------------
  typedef logic [`MHP_DW-1:0]   mhp_word_t;
  typedef logic [`MHP_AW-1:0]   mhp_idx_t;
  typedef logic [`MHP_NBLK-1:0] mhp_blkvec_t;

  // ----------------------------------------------------------------
  // Sequencer states of the processor-side engines
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MHP_M_RUN,
    MHP_M_WAIT_SET,
    MHP_M_WAIT_CLR
  } mhp_mst_t;

  typedef enum logic [1:0] {
    MHP_S_IDLE,
    MHP_S_READ,
    MHP_S_DRAIN
  } mhp_slv_t;

endpackage : mhp_pkg

// ### verif/mhp_checker.sv
/*
  Checker for the handshake of one block seen on the joining interface.
  Assumes one clock, block BLK alone enabled, protocol word PROTO.
*/
`timescale 1ns/1ps
`default_nettype none

module mhp_checker #(
  parameter int BLK   = 0,
  parameter int PROTO = 5
) (
  input wire logic                 CLOCK,
  input wire logic                 RESET_N,
  input wire mhp_pkg::mhp_idx_t    m_addr,
  input wire logic                 m_wr,
  input wire mhp_pkg::mhp_blkvec_t m_flags,
  input wire mhp_pkg::mhp_blkvec_t m_irq,
  input wire mhp_pkg::mhp_idx_t    s_addr,
  input wire logic                 s_rd,
  input wire mhp_pkg::mhp_blkvec_t s_flags,
  input wire mhp_pkg::mhp_blkvec_t s_irq
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  // ------------------------------------------------------------
  // Steps: protocol write, and the receiver read that ends it
  // ------------------------------------------------------------
  sequence seq_wr;
    m_wr && m_addr == PROTO;
  endsequence
  sequence seq_rd;
    s_rd && s_addr == PROTO && s_flags[BLK];
  endsequence

  // Far-side views lag one stage, so the crossing never skips
  property p_tx_set;
    seq_wr |=> m_flags[BLK];
  endproperty
  property p_rx_set;
    seq_wr |=> !s_flags[BLK] ##1 (s_flags[BLK] && s_irq[BLK]);
  endproperty
  property p_rx_clr;
    seq_rd |=> !s_flags[BLK];
  endproperty
  property p_tx_clr;
    seq_rd |=> m_flags[BLK] ##1 (!m_flags[BLK] && m_irq[BLK]);
  endproperty
  property p_irq_rx;
    s_irq[BLK] |-> $rose(s_flags[BLK]);
  endproperty
  property p_irq_tx;
    m_irq[BLK] |-> $fell(m_flags[BLK]);
  endproperty
  // Only a transmitter write may start a transfer
  property p_tx_cause;
    $rose(m_flags[BLK]) |-> $past(m_wr) && $past(m_addr) == PROTO;
  endproperty
  property p_silent;
    ((m_flags | s_flags | m_irq | s_irq) & ~(8'h01 << BLK)) == 8'h00;
  endproperty

  a_tx_set: assert property (p_tx_set)
    else $error("transmitter flag not set");
  a_rx_set: assert property (p_rx_set)
    else $error("receiver flag or irq wrong after write");
  a_rx_clr: assert property (p_rx_clr)
    else $error("receiver flag not cleared");
  a_tx_clr: assert property (p_tx_clr)
    else $error("transmitter flag or irq wrong after read");
  a_irq_rx: assert property (p_irq_rx)
    else $error("receiver irq without flag rise");
  a_irq_tx: assert property (p_irq_tx)
    else $error("transmitter irq without flag fall");
  a_tx_cause: assert property (p_tx_cause)
    else $error("flag rose without protocol write");
  a_silent: assert property (p_silent)
    else $error("disabled block active");
endmodule : mhp_checker

`default_nettype wire

// ### verif/test_mailbox_handshake_pipe.sv
/*
  Testbench: host end joined to a device, plus a second device driven
  straight from its register ports. Assumes hdl/ is compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
  n_errors++; $display("Error t=%0t got %h exp %h", $time, got, exp); \
  end end

module test_mailbox_handshake_pipe;
  logic        CLOCK;
  logic        RESET_N;
  logic        rst_b_n;
  logic [15:0] dir_b;
  logic [31:0] asg_b;
  logic [7:0]  en_b;
  logic [3:0]  rx_len;
  logic        tx_valid;
  logic        tx_ready;
  logic [15:0] tx_data;
  logic        tx_last;
  logic        rx_valid;
  logic [15:0] rx_data;
  logic        rx_last;
  logic        refused;
  int          n_errors;
  int          comparisons;
  logic [16:0] expq[$];
  logic [16:0] gotq[$];
  logic [15:0] rows[8];

  mhp_if bus_a ();
  mhp_if bus_b ();

  // Fuses are captured once after reset, so sharing dir_b is harmless
  mhp_mailbox_dev mhp_mailbox_dev_inst (.CLOCK(CLOCK), .RESET_N(RESET_N),
    .DIR_FUSES(dir_b), .ASSIGN_FUSES(32'h0000_0005),
    .ENABLE_FUSES(8'h01), .BUS(bus_a));
  mhp_mailbox_dev mhp_mailbox_dev_inst_b (.CLOCK(CLOCK), .RESET_N(rst_b_n),
    .DIR_FUSES(dir_b), .ASSIGN_FUSES(asg_b), .ENABLE_FUSES(en_b),
    .BUS(bus_b));
  mhp_mailbox_host mhp_mailbox_host_inst (.CLOCK(CLOCK), .RESET_N(RESET_N),
    .BLOCK_SEL(3'h0), .FIRST_REG(4'h0), .PROTO_REG(4'h5), .RX_LEN(rx_len),
    .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_DATA(tx_data),
    .TX_LAST(tx_last), .RX_VALID(rx_valid), .RX_DATA(rx_data),
    .RX_LAST(rx_last), .BUS(bus_a));
  mhp_checker mhp_checker_inst (.CLOCK(CLOCK), .RESET_N(RESET_N),
    .m_addr(bus_a.m_addr), .m_wr(bus_a.m_wr), .m_flags(bus_a.m_flags),
    .m_irq(bus_a.m_irq), .s_addr(bus_a.s_addr), .s_rd(bus_a.s_rd),
    .s_flags(bus_a.s_flags), .s_irq(bus_a.s_irq));

  // ------------------------------------------------------------
  // Clock, receive monitor, watchdog
  // ------------------------------------------------------------
  initial begin
    CLOCK = 1'b0;
    forever #50 CLOCK = ~CLOCK;
  end

  // Receive side has no back-pressure, so every pulse is kept;
  // sampled mid-cycle, where the one-cycle pulse has settled
  always @(negedge CLOCK) begin
    if (rx_valid === 1'b1) gotq.push_back({rx_last, rx_data});
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (6000) @(posedge CLOCK);
    n_errors++;
    report_and_stop();
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  task automatic tick(input int n);
    repeat (n) @(negedge CLOCK);
  endtask : tick

  // One access on the second device; sl picks the slave port
  task automatic acc(input logic sl, input logic w, input logic [3:0] a,
                     input logic [15:0] d);
    @(negedge CLOCK);
    bus_b.m_addr = a;
    bus_b.s_addr = a;
    bus_b.m_wdata = d;
    bus_b.s_wdata = d;
    bus_b.m_wr = w & ~sl;
    bus_b.m_rd = ~w & ~sl;
    bus_b.s_wr = w & sl;
    bus_b.s_rd = ~w & sl;
    @(negedge CLOCK);
    {bus_b.m_wr, bus_b.m_rd, bus_b.s_wr, bus_b.s_rd} = 4'h0;
  endtask : acc

  function automatic logic [7:0] fl(input logic sl);
    return sl ? bus_b.s_flags : bus_b.m_flags;
  endfunction : fl
  function automatic logic [7:0] ir(input logic sl);
    return sl ? bus_b.s_irq : bus_b.m_irq;
  endfunction : ir
  function automatic logic [15:0] rd(input logic sl);
    return sl ? bus_b.s_rdata : bus_b.m_rdata;
  endfunction : rd

  // Pushes n words as fast as the FIFO takes them, noting refusals
  task automatic push(input int n, input int len, input logic [15:0] base);
    int i;
    i = 0;
    while (i < n) begin
      @(negedge CLOCK);
      tx_valid = 1'b1;
      tx_data = base + 16'(i);
      tx_last = (i % len) == len - 1;
      if (tx_ready === 1'b1) begin
        expq.push_back({tx_last, tx_data});
        i++;
      end else begin
        refused = 1'b1;
      end
    end
    @(negedge CLOCK);
    tx_valid = 1'b0;
  endtask : push

  task automatic drain();
    int k;
    for (k = 0; k < 3000 && gotq.size() < expq.size(); k++) tick(1);
    `CHK(gotq.size(), expq.size())
    for (k = 0; k < expq.size(); k++) `CHK(gotq[k], expq[k])
    expq.delete();
    gotq.delete();
  endtask : drain

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    int          r;
    logic [2:0]  b;
    logic [3:0]  ix;
    logic        sl;
    logic [7:0]  e;
    logic [15:0] d;
    // Rows: block, protocol word, slave transmits, enabled
    rows = '{16'h0501, 16'h1f11, 16'h2000, 16'h3111,
             16'h4701, 16'h5911, 16'h6301, 16'h7c11};
    {n_errors, comparisons} = '0;
    {RESET_N, rst_b_n, refused, tx_valid, tx_last} = '0;
    {dir_b, asg_b, en_b, tx_data} = '0;
    rx_len = 4'h2;
    {bus_b.m_addr, bus_b.m_wdata, bus_b.s_addr, bus_b.s_wdata} = '0;
    {bus_b.m_wr, bus_b.m_rd, bus_b.s_wr, bus_b.s_rd} = 4'h0;
    tick(16);
    RESET_N = 1'b1;
    rst_b_n = 1'b1;
    tick(2);
    push(12, 3, 16'ha000);
    drain();
    $display("three-word buffers done");
    rx_len = 4'h0;
    push(24, 1, 16'hb000);
    `CHK(refused, 1'b1)
    drain();
    $display("fill and drain done");
    for (r = 0; r < 8; r++) begin
      b = rows[r][14:12];
      ix = rows[r][11:8];
      sl = rows[r][4];
      e = 8'(rows[r][0]) << b;
      d = {4'ha, 1'b0, b, ix, 4'h5};
      dir_b = {16{sl}};
      asg_b = 32'(ix) << (4 * b);
      en_b = e;
      rst_b_n = 1'b0;
      tick(2);
      rst_b_n = 1'b1;
      tick(2);
      `CHK(bus_b.m_flags | bus_b.s_flags, 8'h00)
      acc(sl, 1'b1, ix ^ 4'h1, ~d);
      `CHK(fl(sl) | fl(~sl), 8'h00)
      // Own side flag moves at the taking edge, far side one edge later
      acc(sl, 1'b1, ix, d);
      `CHK(fl(sl), e)
      `CHK(fl(~sl), 8'h00)
      tick(1);
      `CHK(fl(~sl), e)
      `CHK(ir(~sl), e)
      acc(~sl, 1'b1, ix, 16'hdead);
      acc(~sl, 1'b0, ix ^ 4'h1, 16'h0000);
      tick(1);
      `CHK(rd(~sl), ~d)
      acc(~sl, 1'b0, ix, 16'h0000);
      `CHK(rd(~sl), d)
      `CHK(fl(~sl), 8'h00)
      `CHK(fl(sl), e)
      tick(1);
      `CHK(fl(sl), 8'h00)
      `CHK(ir(sl), e)
      acc(~sl, 1'b0, ix, 16'h0000);
      tick(2);
      `CHK(ir(sl) | fl(sl), 8'h00)
      `CHK(rd(~sl), d)
      $display("row %0d done", r);
    end
    // Reset in mid-transfer: flags go, stored words stay
    acc(sl, 1'b1, ix, ~d);
    tick(2);
    rst_b_n = 1'b0;
    tick(1);
    rst_b_n = 1'b1;
    tick(2);
    `CHK(bus_b.m_flags | bus_b.s_flags, 8'h00)
    acc(~sl, 1'b0, ix, 16'h0000);
    tick(1);
    `CHK(rd(~sl), ~d)
    $display("reset keeps data done");
    report_and_stop();
  end
endmodule : test_mailbox_handshake_pipe

`default_nettype wire
